// ---- hdl/csia_pkg.sv ----
// Shared constants and types for the CPU stack and indirect addressing block
package csia_pkg;

  // ==========================================================
  // Return stack
  localparam int STACK_DEPTH = 16;        // Entries in the return stack
  localparam int RET_ADDR_W = 15;         // Width of one return address
  localparam int STACK_CNT_W = 5;         // Holds 0..STACK_DEPTH

  // ==========================================================
  // Context shadow
  localparam int CTX_W = 48;              // Packed core registers saved

  // ==========================================================
  // Indirect pointers and their unified address map
  localparam int PTR_W = 16;              // Width of one pointer
  localparam int PTR_COUNT = 2;           // Number of pointers
  localparam logic [15:0] LIN_BASE = 16'h2000;   // Linear GPR view start
  localparam logic [15:0] LIN_LAST = 16'h2fef;   // Linear GPR view end
  localparam logic [15:0] EE_BASE = 16'h7000;    // Data EEPROM start
  localparam logic [15:0] EE_LAST = 16'h70ff;    // Data EEPROM end
  localparam logic [15:0] PROG_BASE = 16'h8000;  // Program memory start
  localparam logic [15:0] GPR_BYTES = 16'h0050;  // GPR bytes in one bank
  localparam logic [6:0] GPR_OFFSET = 7'h20;     // GPR start inside a bank
  localparam int BANK_SHIFT = 7;                 // Bank field position

  // Memory that an indirect access lands in
  typedef enum logic [1:0] {
    CSIA_SPACE_FILE,
    CSIA_SPACE_EE,
    CSIA_SPACE_PROG
  } csia_space_t;

endpackage

// ---- hdl/csia_ret_stack.sv ----
// Sixteen-entry hardware return-address stack with error detection
`timescale 1ns/1ps
`default_nettype none

module csia_ret_stack #(
  parameter int DEPTH = csia_pkg::STACK_DEPTH,   // Entries
  parameter int AW = csia_pkg::RET_ADDR_W        // Address width
) (
  input wire logic clk_i,                         // Core clock
  input wire logic rst_n_i,                       // Async reset, low
  input wire logic push_i,                        // Push request
  input wire logic pop_i,                         // Pop request
  input wire logic [AW-1:0] push_addr_i,          // Address to push
  output logic [AW-1:0] tos_o,                    // Top entry
  output logic [csia_pkg::STACK_CNT_W-1:0] depth_o, // Entries held
  output logic ovf_o,                             // Overflow pulse
  output logic unf_o                              // Underflow pulse
);

  // ==========================================================
  // Storage
  logic [AW-1:0] mem [DEPTH];                     // Entries, separate RAM
  logic [csia_pkg::STACK_CNT_W-1:0] cnt_reg;      // Entries held
  logic [AW-1:0] tos_reg;                         // Copy of the top entry
  logic ovf_reg;                                  // Overflow event
  logic unf_reg;                                  // Underflow event
  logic do_push;                                  // Accepted push
  logic do_pop;                                   // Accepted pop

  // Push wins when both arrive together
  assign do_push = push_i && (cnt_reg != DEPTH[csia_pkg::STACK_CNT_W-1:0]);
  assign do_pop = pop_i && !push_i && (cnt_reg != '0);

  // Entry writes, no reset needed on the array
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[cnt_reg[3:0]] <= push_addr_i;
    end
  end

  // Depth counter and the top copy kept ready for a return
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      tos_reg <= '0;
    end else if (do_push) begin
      cnt_reg <= cnt_reg + 5'h01;
      tos_reg <= push_addr_i;
    end else if (do_pop) begin
      cnt_reg <= cnt_reg - 5'h01;
      // Entry below the top becomes visible, zero when emptied
      tos_reg <= (cnt_reg >= 5'h02) ? mem[4'(cnt_reg - 5'h02)] : '0;
    end
  end

  // Error events, one cycle each
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      ovf_reg <= push_i && !do_push;
      unf_reg <= pop_i && !push_i && (cnt_reg == '0);
    end
  end

  assign tos_o = tos_reg;
  assign depth_o = cnt_reg;
  assign ovf_o = ovf_reg;
  assign unf_o = unf_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_push_top: assert property (
    push_i |=> tos_reg == $past(push_addr_i) || ovf_reg)
    else $error("pushed address not on top");

  chk_depth_bound: assert property (
    cnt_reg <= DEPTH[csia_pkg::STACK_CNT_W-1:0])
    else $error("stack depth beyond limit");

endmodule

`default_nettype wire

// ---- hdl/csia_core.sv ----
// Context shadow, return stack control and indirect pointer resolution
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Shadow core registers on interrupt, restore on return
// - Sixteen deep, fifteen bit return stack
// - Sticky overflow and underflow flags on stack errors
// - Optional software reset on stack error
// - Two independent sixteen bit indirect pointers
// - Pointers reach file, program and EEPROM space
// - Program memory access adds one cycle
// - Linear gapless view of general purpose memory
module csia_core #(
  parameter int CTX_W = csia_pkg::CTX_W,          // Shadowed bits
  parameter int DEPTH = csia_pkg::STACK_DEPTH     // Stack entries
) (
  input wire logic CLOCK_I,                       // Core clock, 40 MHz
  input wire logic RESETN_I,                      // Async reset, low
  input wire logic INT_ENTRY_I,                   // Interrupt entry pulse
  input wire logic INT_RETURN_I,                  // Interrupt return pulse
  input wire logic [CTX_W-1:0] CTX_LIVE_I,        // Live core registers
  output logic [CTX_W-1:0] CTX_SHADOW_O,          // Values to restore
  output logic CTX_RESTORE_O,                     // Restore strobe
  input wire logic PUSH_I,                        // Call or entry push
  input wire logic POP_I,                         // Return pop
  input wire logic [csia_pkg::RET_ADDR_W-1:0] PUSH_ADDR_I, // Return addr
  output logic [csia_pkg::RET_ADDR_W-1:0] TOS_O,  // Address a pop returns
  output logic [csia_pkg::STACK_CNT_W-1:0] DEPTH_O, // Entries held
  output logic STACK_OVERFLOW_FLAG_O,             // Sticky overflow
  output logic STACK_UNDERFLOW_FLAG_O,            // Sticky underflow
  input wire logic FLAG_CLEAR_I,                  // Clears both flags
  input wire logic STACK_RESET_EN_I,              // Reset on stack error
  output logic SOFT_RESET_O,                      // Software reset pulse
  input wire logic PTR_WE_I,                      // Pointer write
  input wire logic PTR_WSEL_I,                    // Pointer written
  input wire logic [csia_pkg::PTR_W-1:0] PTR_WDATA_I, // Pointer value
  output logic [csia_pkg::PTR_W-1:0] PTR0_O,      // Pointer 0
  output logic [csia_pkg::PTR_W-1:0] PTR1_O,      // Pointer 1
  input wire logic IND_REQ_I,                     // Data port access
  input wire logic IND_SEL_I,                     // Pointer used
  output logic [1:0] MEM_SPACE_O,                 // Target memory
  output logic [csia_pkg::PTR_W-1:0] MEM_ADDR_O,  // Address in target
  output logic MEM_VALID_O,                       // Address valid
  output logic EXTRA_CYCLE_O                      // Sequencer must wait
);

  // ==========================================================
  // Context shadow
  logic [CTX_W-1:0] shadow_reg;                   // Saved core registers
  logic restore_reg;                              // Restore strobe

  // Capture on entry, hand back on return
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      shadow_reg <= '0;
      restore_reg <= 1'b0;
    end else begin
      if (INT_ENTRY_I) begin
        shadow_reg <= CTX_LIVE_I;
      end
      restore_reg <= INT_RETURN_I;
    end
  end

  assign CTX_SHADOW_O = shadow_reg;
  assign CTX_RESTORE_O = restore_reg;

  // ==========================================================
  // Return stack
  logic ovf_ev;                                   // Overflow event
  logic unf_ev;                                   // Underflow event

  csia_ret_stack #(
    .DEPTH(DEPTH),
    .AW(csia_pkg::RET_ADDR_W)
  ) u_stack (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .push_i(PUSH_I),
    .pop_i(POP_I),
    .push_addr_i(PUSH_ADDR_I),
    .tos_o(TOS_O),
    .depth_o(DEPTH_O),
    .ovf_o(ovf_ev),
    .unf_o(unf_ev)
  );

  // ==========================================================
  // Reset cause flags and software reset
  logic ovf_flag_reg;                             // Sticky overflow
  logic unf_flag_reg;                             // Sticky underflow
  logic soft_reset_reg;                           // Reset request

  // Set beats clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ovf_flag_reg <= 1'b0;
      unf_flag_reg <= 1'b0;
    end else begin
      ovf_flag_reg <= ovf_ev || (ovf_flag_reg && !FLAG_CLEAR_I);
      unf_flag_reg <= unf_ev || (unf_flag_reg && !FLAG_CLEAR_I);
    end
  end

  // Error turns into a reset only when the option is on
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= STACK_RESET_EN_I && (ovf_ev || unf_ev);
    end
  end

  assign STACK_OVERFLOW_FLAG_O = ovf_flag_reg;
  assign STACK_UNDERFLOW_FLAG_O = unf_flag_reg;
  assign SOFT_RESET_O = soft_reset_reg;

  // ==========================================================
  // Indirect pointers
  logic [csia_pkg::PTR_W-1:0] ptr_reg [csia_pkg::PTR_COUNT]; // Pointers

  // Each pointer written on its own
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ptr_reg[0] <= '0;
      ptr_reg[1] <= '0;
    end else if (PTR_WE_I) begin
      ptr_reg[PTR_WSEL_I] <= PTR_WDATA_I;
    end
  end

  assign PTR0_O = ptr_reg[0];
  assign PTR1_O = ptr_reg[1];

  // Which memory a pointer value selects
  function automatic csia_pkg::csia_space_t space_of(
    input logic [csia_pkg::PTR_W-1:0] p
  );
    if (p >= csia_pkg::PROG_BASE) begin
      return csia_pkg::CSIA_SPACE_PROG;
    end else if (p >= csia_pkg::EE_BASE && p <= csia_pkg::EE_LAST) begin
      return csia_pkg::CSIA_SPACE_EE;
    end else begin
      return csia_pkg::CSIA_SPACE_FILE;
    end
  endfunction

  // Address inside the selected memory
  function automatic logic [csia_pkg::PTR_W-1:0] addr_of(
    input logic [csia_pkg::PTR_W-1:0] p
  );
    logic [csia_pkg::PTR_W-1:0] lin;
    logic [csia_pkg::PTR_W-1:0] bank;
    logic [csia_pkg::PTR_W-1:0] off;
    lin = p - csia_pkg::LIN_BASE;
    bank = lin / csia_pkg::GPR_BYTES;
    off = lin % csia_pkg::GPR_BYTES;
    if (p >= csia_pkg::PROG_BASE) begin
      return p - csia_pkg::PROG_BASE;
    end else if (p >= csia_pkg::EE_BASE && p <= csia_pkg::EE_LAST) begin
      return p - csia_pkg::EE_BASE;
    end else if (p >= csia_pkg::LIN_BASE && p <= csia_pkg::LIN_LAST) begin
      // Consecutive bytes run across bank GPR windows with no gap
      return (bank << csia_pkg::BANK_SHIFT) +
             {9'h000, csia_pkg::GPR_OFFSET} + off;
    end else begin
      return p;
    end
  endfunction

  // ==========================================================
  // Indirect access sequencing
  typedef enum {CSIA_IDLE, CSIA_FETCH} csia_acc_t;
  csia_acc_t acc_reg;                             // Access state
  logic [csia_pkg::PTR_W-1:0] sel_ptr;            // Pointer in use
  logic [1:0] space_reg;                          // Target memory
  logic [csia_pkg::PTR_W-1:0] addr_reg;           // Target address
  logic valid_reg;                                // Address valid
  logic extra_reg;                                // Wait one more cycle

  assign sel_ptr = ptr_reg[IND_SEL_I];

  // Resolve the pointer, hold program fetches one extra cycle
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      acc_reg <= CSIA_IDLE;
      space_reg <= 2'h0;
      addr_reg <= '0;
      valid_reg <= 1'b0;
      extra_reg <= 1'b0;
    end else begin
      case (acc_reg)
        CSIA_IDLE: begin
          valid_reg <= IND_REQ_I;
          extra_reg <= 1'b0;
          if (IND_REQ_I) begin
            space_reg <= space_of(sel_ptr);
            addr_reg <= addr_of(sel_ptr);
            if (space_of(sel_ptr) == csia_pkg::CSIA_SPACE_PROG) begin
              acc_reg <= CSIA_FETCH;
              extra_reg <= 1'b1;
            end
          end
        end
        CSIA_FETCH: begin
          // Address stays put while the program word is read
          extra_reg <= 1'b0;
          valid_reg <= 1'b1;
          acc_reg <= CSIA_IDLE;
        end
        default: begin
          acc_reg <= CSIA_IDLE;
          valid_reg <= 1'b0;
          extra_reg <= 1'b0;
        end
      endcase
    end
  end

  assign MEM_SPACE_O = space_reg;
  assign MEM_ADDR_O = addr_reg;
  assign MEM_VALID_O = valid_reg;
  assign EXTRA_CYCLE_O = extra_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_prog_req;
    IND_REQ_I && acc_reg == CSIA_IDLE && sel_ptr >= csia_pkg::PROG_BASE;
  endsequence

  // A return with no entry beside it hands back the saved copy untouched
  chk_ctx_restore: assert property (
    INT_RETURN_I && !INT_ENTRY_I
    |=> CTX_RESTORE_O && CTX_SHADOW_O == $past(shadow_reg))
    else $error("restore does not show shadow");

  chk_ctx_capture: assert property (
    INT_ENTRY_I |=> shadow_reg == $past(CTX_LIVE_I))
    else $error("shadow not captured on entry");

  chk_ovf_flag: assert property (
    ovf_ev |=> STACK_OVERFLOW_FLAG_O)
    else $error("overflow flag not set");

  chk_unf_sticky: assert property (
    STACK_UNDERFLOW_FLAG_O && !FLAG_CLEAR_I |=> STACK_UNDERFLOW_FLAG_O)
    else $error("underflow flag lost");

  chk_soft_reset: assert property (
    (ovf_ev || unf_ev) |=> SOFT_RESET_O == $past(STACK_RESET_EN_I))
    else $error("software reset mismatch");

  chk_prog_wait: assert property (
    s_prog_req |=> EXTRA_CYCLE_O ##1 (!EXTRA_CYCLE_O && MEM_VALID_O))
    else $error("program access not one cycle longer");

  chk_file_nowait: assert property (
    IND_REQ_I && acc_reg == CSIA_IDLE && sel_ptr < csia_pkg::EE_BASE
    |=> !EXTRA_CYCLE_O && MEM_VALID_O)
    else $error("file access stalled");

  chk_ptr_write: assert property (
    PTR_WE_I && !PTR_WSEL_I |=> PTR0_O == $past(PTR_WDATA_I)
    && PTR1_O == $past(PTR1_O))
    else $error("pointer write disturbed other");

  chk_linear_map: assert property (
    IND_REQ_I && acc_reg == CSIA_IDLE && sel_ptr == csia_pkg::LIN_BASE
    |=> MEM_ADDR_O == {9'h000, csia_pkg::GPR_OFFSET})
    else $error("linear view start misplaced");

endmodule

`default_nettype wire

// ---- test/csia_seq_model.sv ----
// Sequencer model that turns calls, returns and interrupts into requests
`timescale 1ns/1ps
`default_nettype none

module csia_seq_model (
  input wire logic clk_i,                                   // Core clock
  input wire logic call_i,                                  // Call issued
  input wire logic ret_i,                                   // Return issued
  input wire logic irq_i,                                   // Interrupt taken
  input wire logic iret_i,                                  // Interrupt return
  input wire logic [csia_pkg::RET_ADDR_W-1:0] tos_i,        // Stack top
  output logic push_o,                                      // Push request
  output logic pop_o,                                       // Pop request
  output logic int_entry_o,                                 // Shadow save
  output logic int_return_o,                                // Shadow restore
  output logic [csia_pkg::RET_ADDR_W-1:0] ret_addr_o        // Address popped
);
  // ==========================================================
  // Request mapping
  // Calls and interrupt entries push, both kinds of return pop
  assign push_o = call_i | irq_i;
  assign pop_o = ret_i | iret_i;
  assign int_entry_o = irq_i;
  assign int_return_o = iret_i;

  // ==========================================================
  // Return address capture
  // The popped address must already stand at the top in the pop cycle
  always_ff @(posedge clk_i) begin
    if (pop_o) begin
      ret_addr_o <= tos_i;
    end
  end
endmodule

`default_nettype wire

// ---- test/csia_core_bench.sv ----
// Self-checking bench for the stack, context and indirect pointer block
`timescale 1ns/1ps
`default_nettype none

module csia_core_bench;
  logic clk = 1'b0, rstn = 1'b0;  // Clock and active-low reset
  logic call, ret, irq, iret;  // Sequencer commands
  logic push, pop, ent, rtn;  // Model outputs
  logic [14:0] paddr, tos, raddr;  // Stack addresses
  logic [47:0] live, shadow;  // Context
  logic restore, ovf, unf, fclr, sren, sres;  // Context and stack flags
  logic [4:0] depth;  // Entries held
  logic we, wsel, ireq, isel, mvalid, extra;  // Pointer controls
  logic [15:0] wdata, p0, p1, maddr;  // Pointer values
  logic [1:0] space;  // Target memory
  int failures = 0, samples_checked = 0, cycles = 0;  // Counters

  // ==========================================================
  // Clock, timeout
  always #12.5 clk = ~clk;
  // Stop a hung run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end

  // ==========================================================
  // Instances
  csia_seq_model seq (.clk_i(clk), .call_i(call), .ret_i(ret), .irq_i(irq),
    .iret_i(iret), .tos_i(tos), .push_o(push), .pop_o(pop),
    .int_entry_o(ent), .int_return_o(rtn), .ret_addr_o(raddr));
  csia_core DUT (.CLOCK_I(clk), .RESETN_I(rstn), .INT_ENTRY_I(ent),
    .INT_RETURN_I(rtn), .CTX_LIVE_I(live), .CTX_SHADOW_O(shadow),
    .CTX_RESTORE_O(restore), .PUSH_I(push), .POP_I(pop),
    .PUSH_ADDR_I(paddr), .TOS_O(tos), .DEPTH_O(depth),
    .STACK_OVERFLOW_FLAG_O(ovf), .STACK_UNDERFLOW_FLAG_O(unf),
    .FLAG_CLEAR_I(fclr), .STACK_RESET_EN_I(sren), .SOFT_RESET_O(sres),
    .PTR_WE_I(we), .PTR_WSEL_I(wsel), .PTR_WDATA_I(wdata), .PTR0_O(p0),
    .PTR1_O(p1), .IND_REQ_I(ireq), .IND_SEL_I(isel), .MEM_SPACE_O(space),
    .MEM_ADDR_O(maddr), .MEM_VALID_O(mvalid), .EXTRA_CYCLE_O(extra));

  // ==========================================================
  // Shared tasks
  // Compare one value with its expectation
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Fill to the top, overflow with reset enabled, drain, underflow without
  task automatic t_stack();
    sren = 1'b1;
    call = 1'b1;
    for (int i = 0; i < 16; i++) begin
      paddr = 15'h0100 + 15'(i);
      @(negedge clk);
      chk(tos, 48'h0100 + 48'(i));
      chk(depth, 48'(i + 1));
    end
    paddr = 15'h7fff;
    @(negedge clk);
    call = 1'b0;
    chk(depth, 48'h10);
    chk(tos, 48'h010f);
    @(negedge clk);
    chk(ovf, 48'h1);
    chk(sres, 48'h1);
    @(negedge clk);
    chk(sres, 48'h0);
    chk(ovf, 48'h1);
    sren = 1'b0;
    ret = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      chk(raddr, 48'h0100 + 48'(i));
      chk(depth, 48'(i));
    end
    @(negedge clk);
    ret = 1'b0;
    chk(depth, 48'h0);
    @(negedge clk);
    chk(unf, 48'h1);
    chk(sres, 48'h0);
    @(negedge clk);
    chk(sres, 48'h0);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    @(negedge clk);
    chk({ovf, unf}, 48'h0);
    $display("test stack done");
  endtask

  // Save context on entry, restore it on return
  task automatic t_ctx();
    live = 48'h123456789abc;
    paddr = 15'h0abc;
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
    live = 48'h0;
    chk(shadow, 48'h123456789abc);
    chk(depth, 48'h1);
    iret = 1'b1;
    @(negedge clk);
    iret = 1'b0;
    chk(raddr, 48'h0abc);
    chk(restore, 48'h1);
    chk(shadow, 48'h123456789abc);
    @(negedge clk);
    chk(restore, 48'h0);
    $display("test context done");
  endtask

  // Write a pointer, then read through the data port with it
  task automatic ind(input logic [15:0] p, input logic s,
                     input logic [1:0] sp, input logic [15:0] a);
    we = 1'b1;
    wsel = s;
    wdata = p;
    @(negedge clk);
    we = 1'b0;
    chk(s ? p1 : p0, p);
    ireq = 1'b1;
    isel = s;
    @(negedge clk);
    ireq = 1'b0;
    chk({mvalid, space, maddr}, {1'b1, sp, a});
    chk(extra, 48'(sp == 2'd2));
    if (sp == 2'd2) begin
      @(negedge clk);
      chk({mvalid, extra}, 48'h2);
    end
    @(negedge clk);
    chk(mvalid, 48'h0);
  endtask

  // Every region of the unified map, both pointers in turn
  task automatic t_ind();
    ind(16'h0123, 1'b0, 2'd0, 16'h0123);
    ind(16'h2000, 1'b1, 2'd0, 16'h0020);
    ind(16'h204f, 1'b0, 2'd0, 16'h006f);
    ind(16'h2050, 1'b1, 2'd0, 16'h00a0);
    ind(16'h2fef, 1'b0, 2'd0, 16'h196f);
    ind(16'h7010, 1'b1, 2'd1, 16'h0010);
    ind(16'h8005, 1'b0, 2'd2, 16'h0005);
    ind(16'hffff, 1'b1, 2'd2, 16'h7fff);
    chk({p0, p1}, 48'h8005ffff);
    $display("test indirect done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {call, ret, irq, iret, fclr, sren, we, wsel, ireq, isel} = '0;
    paddr = '0;
    live = '0;
    wdata = '0;
    repeat (7) @(negedge clk);
    rstn = 1'b1;
    chk({depth, ovf, unf, sres, mvalid, extra, p0}, 48'h0);
    t_stack();
    t_ctx();
    t_ind();
    end_of_test();
  end
endmodule

`default_nettype wire
